// *** core/tuning_pkg.sv ***
// constants and carrier types shared by the resonator tuning control
// assumes a 100 MHz modulator clock and the serial control port framing
package tuning_pkg;
    localparam int CLK_HZ = 100_000_000;
    // register offsets on the serial control port
    localparam logic [6:0] ADDR_STANDBY = 7'h00;
    localparam logic [6:0] ADDR_GAIN = 7'h03;
    localparam logic [6:0] ADDR_CAL_REQ = 7'h1C;
    localparam logic [6:0] ADDR_TANK_UPPER = 7'h1D;
    localparam logic [6:0] ADDR_TANK_LOWER = 7'h1E;
    localparam logic [6:0] ADDR_FILTER_CODE = 7'h1F;
    // reset values and field positions
    localparam logic [7:0] STANDBY_RESET = 8'hFF;
    localparam int ADC_STANDBY_BIT = 0;
    localparam int GAIN_STEP_BIT = 7;
    localparam int TANK_REQ_BIT = 1;
    localparam int FILTER_REQ_BIT = 0;
    localparam int TANK_BITS = 9;
    localparam int FILTER_BITS = 8;
    // serial frame: read flag, 7-bit address, 8 data bits
    localparam int FRAME_BITS = 16;
    localparam int HEADER_BITS = 8;
    // whole calibration must finish inside this bound (longest: round down)
    localparam int CAL_LIMIT_MS = 6;
    localparam int CAL_LIMIT_CYCLES = CAL_LIMIT_MS * (CLK_HZ / 1000);
    // settling per trial capacitor code (least: round up)
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYCLES =
        (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef struct packed {
        logic lc_done;
        logic rc_done;
        logic timeout;
    } cal_event_t;

    typedef struct packed {
        logic [2:0] upper;
        logic [5:0] lower;
    } tank_code_t;
endpackage

// *** core/tune_engine.sv ***
// successive-approximation search of the tank and filter capacitor codes
// assumes an analog comparator answering each trial code after settling
`timescale 1ns/1ps
`default_nettype none
module tune_engine #(
    parameter int TANK_BITS = tuning_pkg::TANK_BITS,
    parameter int FILTER_BITS = tuning_pkg::FILTER_BITS,
    parameter int SETTLE_CYCLES = tuning_pkg::SETTLE_CYCLES,
    parameter int LIMIT_CYCLES = tuning_pkg::CAL_LIMIT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic want_lc,
    input wire logic want_rc,
    input wire logic cmp_high,
    output logic busy,
    output logic [TANK_BITS-1:0] trial_code,
    output logic [TANK_BITS-1:0] result_tank,
    output logic [FILTER_BITS-1:0] result_filter,
    output tuning_pkg::cal_event_t events
);
    localparam int SW = $clog2(SETTLE_CYCLES + 1);
    localparam int LW = $clog2(LIMIT_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);
    localparam logic [LW-1:0] LIMIT_END = LW'(LIMIT_CYCLES - 1);
    localparam logic [3:0] TANK_TOP = 4'(TANK_BITS - 1);
    localparam logic [3:0] FILTER_TOP = 4'(FILTER_BITS - 1);

    if (TANK_BITS > 16 || FILTER_BITS > TANK_BITS || FILTER_BITS < 1 ||
        SETTLE_CYCLES < 1 || LIMIT_CYCLES < 2) begin : g_bad_params
        $error("tune_engine: unsupported parameter values");
    end

    typedef enum logic [1:0] {S_IDLE, S_TANK, S_FILTER} state_t;

    state_t state_reg, state_next;
    logic [TANK_BITS-1:0] code_reg, code_next, keep;
    logic [3:0] idx_reg, idx_next;
    logic [SW-1:0] settle_reg, settle_next;
    logic [LW-1:0] elapsed_reg, elapsed_next;
    logic want_rc_reg, want_rc_next;
    logic [TANK_BITS-1:0] res_tank_reg, res_tank_next;
    logic [FILTER_BITS-1:0] res_filter_reg, res_filter_next;
    tuning_pkg::cal_event_t ev_reg, ev_next;

    function automatic logic [TANK_BITS-1:0] bit_at(input logic [3:0] i);
        bit_at = '0;
        bit_at[i] = 1'b1;
    endfunction

    always_comb begin
        state_next = state_reg;
        code_next = code_reg;
        idx_next = idx_reg;
        settle_next = settle_reg;
        elapsed_next = elapsed_reg;
        want_rc_next = want_rc_reg;
        res_tank_next = res_tank_reg;
        res_filter_next = res_filter_reg;
        ev_next = '0;
        keep = cmp_high ? code_reg : (code_reg & ~bit_at(idx_reg));
        case (state_reg)
            S_IDLE: begin
                if (start && (want_lc || want_rc)) begin
                    want_rc_next = want_rc;
                    elapsed_next = '0;
                    settle_next = SETTLE_LOAD;
                    // tank always goes first, filter only afterwards
                    if (want_lc) begin
                        state_next = S_TANK;
                        idx_next = TANK_TOP;
                        code_next = bit_at(TANK_TOP);
                    end else begin
                        state_next = S_FILTER;
                        idx_next = FILTER_TOP;
                        code_next = bit_at(FILTER_TOP);
                    end
                end
            end
            S_TANK, S_FILTER: begin
                elapsed_next = elapsed_reg + 1'b1;
                if (elapsed_reg == LIMIT_END) begin
                    // give up; requests stay set so the host can retry
                    ev_next.timeout = 1'b1;
                    state_next = S_IDLE;
                end else if (settle_reg != '0) begin
                    settle_next = settle_reg - 1'b1;
                end else if (idx_reg != 4'h0) begin
                    code_next = keep | bit_at(idx_reg - 4'h1);
                    idx_next = idx_reg - 4'h1;
                    settle_next = SETTLE_LOAD;
                end else if (state_reg == S_TANK) begin
                    res_tank_next = keep;
                    ev_next.lc_done = 1'b1;
                    if (want_rc_reg) begin
                        state_next = S_FILTER;
                        idx_next = FILTER_TOP;
                        code_next = bit_at(FILTER_TOP);
                        settle_next = SETTLE_LOAD;
                    end else begin
                        state_next = S_IDLE;
                    end
                end else begin
                    res_filter_next = keep[FILTER_BITS-1:0];
                    ev_next.rc_done = 1'b1;
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= S_IDLE;
            code_reg <= '0;
            idx_reg <= 4'h0;
            settle_reg <= '0;
            elapsed_reg <= '0;
            want_rc_reg <= 1'b0;
            res_tank_reg <= '0;
            res_filter_reg <= '0;
            ev_reg <= '0;
        end else begin
            state_reg <= state_next;
            code_reg <= code_next;
            idx_reg <= idx_next;
            settle_reg <= settle_next;
            elapsed_reg <= elapsed_next;
            want_rc_reg <= want_rc_next;
            res_tank_reg <= res_tank_next;
            res_filter_reg <= res_filter_next;
            ev_reg <= ev_next;
        end
    end

    assign busy = (state_reg != S_IDLE);
    assign trial_code = code_reg;
    assign result_tank = res_tank_reg;
    assign result_filter = res_filter_reg;
    assign events = ev_reg;
endmodule
`default_nettype wire

// *** core/resonator_tuning_control.sv ***
// register file, serial control port and calibration sequencing
// assumes serial port pins synchronous to clk and sclk well below clk/2
`timescale 1ns/1ps
`default_nettype none
// How it works
// - gain step bit lowers mixer gain
// - leaving standby with tank request starts tank
// - tank request self-clears; bounded total time
// - tank result in upper and lower registers
// - filter request tunes filter, then self-clears
// - filter result held in readable register
// - both requested: tank first, then filter
// - converter and sample output idle meanwhile
// - codes survive standby entry and exit
// - codes writable by host or calibration
module resonator_tuning_control #(
    parameter int CAL_LIMIT_CYCLES = tuning_pkg::CAL_LIMIT_CYCLES,
    parameter int SETTLE_CYCLES = tuning_pkg::SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso_out,
    output logic spi_miso_oe,
    input wire logic tune_cmp_high,
    output logic gain_step_down,
    output logic [7:0] block_power_down_control,
    output logic [tuning_pkg::TANK_BITS-1:0] tank_cap_setting,
    output logic [tuning_pkg::FILTER_BITS-1:0] filter_cap_setting,
    output logic cal_busy,
    output logic converter_run,
    output logic sample_out_enable
);
    localparam int TB = tuning_pkg::TANK_BITS;
    localparam int FB = tuning_pkg::FILTER_BITS;
    localparam int HB = tuning_pkg::HEADER_BITS;
    localparam logic [4:0] HDR_CNT = 5'(tuning_pkg::HEADER_BITS);
    localparam logic [4:0] FRAME_CNT = 5'(tuning_pkg::FRAME_BITS);

    logic sclk_prev_reg, sclk_prev_next;
    logic [15:0] shift_reg, shift_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] tx_reg, tx_next;
    logic reading_reg, reading_next;
    logic [7:0] standby_reg, standby_next;
    logic gain_reg, gain_next;
    logic tank_req_reg, tank_req_next;
    logic filter_req_reg, filter_req_next;
    tuning_pkg::tank_code_t tank_code_reg, tank_code_next;
    logic [FB-1:0] filter_code_reg, filter_code_next;
    logic [TB-1:0] tank_drive_reg, tank_drive_next;
    logic [FB-1:0] filter_drive_reg, filter_drive_next;
    logic run_reg, run_next;
    logic [15:0] shift_in;
    logic [7:0] rdata, wdata;
    logic [6:0] waddr;
    logic rise, fall, wr;
    logic start, busy;
    logic [TB-1:0] trial, res_tank;
    logic [FB-1:0] res_filter;
    tuning_pkg::cal_event_t ev;
    logic tank_phase_reg, tank_phase_next, in_tank;

    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    tune_engine #(
        .TANK_BITS(TB),
        .FILTER_BITS(FB),
        .SETTLE_CYCLES(SETTLE_CYCLES),
        .LIMIT_CYCLES(CAL_LIMIT_CYCLES)
    ) u_engine (
        .clk(clk),
        .nrst(nrst),
        .start(start),
        .want_lc(tank_req_reg),
        .want_rc(filter_req_reg),
        .cmp_high(tune_cmp_high),
        .busy(busy),
        .trial_code(trial),
        .result_tank(res_tank),
        .result_filter(res_filter),
        .events(ev)
    );

    // serial port edges and frame decode
    assign rise = spi_sclk && !sclk_prev_reg && !spi_cs_n;
    assign fall = !spi_sclk && sclk_prev_reg && !spi_cs_n;
    assign shift_in = {shift_reg[14:0], spi_mosi};
    assign wr = rise && (cnt_reg == FRAME_CNT - 5'h1) && !shift_in[15];
    assign waddr = shift_in[14:8];
    assign wdata = shift_in[7:0];

    always_comb begin
        rdata = 8'h00;
        case (shift_in[6:0])
            tuning_pkg::ADDR_STANDBY: rdata = standby_reg;
            tuning_pkg::ADDR_GAIN:
                rdata[tuning_pkg::GAIN_STEP_BIT] = gain_reg;
            tuning_pkg::ADDR_CAL_REQ: begin
                rdata[tuning_pkg::TANK_REQ_BIT] = tank_req_reg;
                rdata[tuning_pkg::FILTER_REQ_BIT] = filter_req_reg;
            end
            tuning_pkg::ADDR_TANK_UPPER: rdata[2:0] = tank_code_reg.upper;
            tuning_pkg::ADDR_TANK_LOWER: rdata[5:0] = tank_code_reg.lower;
            tuning_pkg::ADDR_FILTER_CODE: rdata = filter_code_reg;
            default: rdata = 8'h00;
        endcase
    end

    // launch when the converter standby bit is released by a write
    assign start = wr && (waddr == tuning_pkg::ADDR_STANDBY) && !busy &&
        standby_reg[tuning_pkg::ADC_STANDBY_BIT] &&
        !wdata[tuning_pkg::ADC_STANDBY_BIT] &&
        (tank_req_reg || filter_req_reg);

    // the tank phase runs from launch until the tank result is taken
    assign in_tank = busy && tank_phase_reg && !ev.lc_done;

    always_comb begin
        sclk_prev_next = spi_sclk;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        tx_next = tx_reg;
        reading_next = reading_reg;
        standby_next = standby_reg;
        gain_next = gain_reg;
        tank_req_next = tank_req_reg;
        filter_req_next = filter_req_reg;
        tank_code_next = tank_code_reg;
        filter_code_next = filter_code_reg;
        if (spi_cs_n) begin
            cnt_next = 5'h0;
            reading_next = 1'b0;
        end else if (rise) begin
            shift_next = shift_in;
            cnt_next = (cnt_reg == FRAME_CNT - 5'h1) ? 5'h0 : cnt_reg + 5'h1;
            if (cnt_reg == HDR_CNT - 5'h1 && shift_in[HB-1]) begin
                reading_next = 1'b1;
                tx_next = rdata;
            end
        end else if (fall && reading_reg && cnt_reg >= HDR_CNT) begin
            tx_next = {tx_reg[6:0], 1'b0};
        end
        if (rise && cnt_reg == FRAME_CNT - 5'h1) begin
            reading_next = 1'b0;
        end
        // hardware clears first so that a host write in the same cycle wins
        if (ev.lc_done) begin
            tank_req_next = 1'b0;
            tank_code_next = res_tank;
        end
        if (ev.rc_done) begin
            filter_req_next = 1'b0;
            filter_code_next = res_filter;
        end
        if (wr) begin
            case (waddr)
                // standby changes never touch the stored codes
                tuning_pkg::ADDR_STANDBY: standby_next = wdata;
                tuning_pkg::ADDR_GAIN:
                    gain_next = wdata[tuning_pkg::GAIN_STEP_BIT];
                tuning_pkg::ADDR_CAL_REQ: begin
                    tank_req_next = wdata[tuning_pkg::TANK_REQ_BIT];
                    filter_req_next = wdata[tuning_pkg::FILTER_REQ_BIT];
                end
                tuning_pkg::ADDR_TANK_UPPER:
                    tank_code_next.upper = wdata[2:0];
                tuning_pkg::ADDR_TANK_LOWER:
                    tank_code_next.lower = wdata[5:0];
                tuning_pkg::ADDR_FILTER_CODE:
                    filter_code_next = wdata;
                default: ;
            endcase
        end
        // capacitor arrays follow the trial code while tuning
        // each array only in its own phase; both can change together only at the tank-to-filter handover
        tank_phase_next = start ? tank_req_reg :
            (tank_phase_reg && busy && !ev.lc_done);
        tank_drive_next = in_tank ? trial : tank_code_next;
        filter_drive_next = (busy && !in_tank) ? trial[FB-1:0] :
            filter_code_next;
        // datapath stays off until every requested calibration ends
        run_next = !standby_next[tuning_pkg::ADC_STANDBY_BIT] && !busy &&
            !start;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_reg <= 1'b0;
            shift_reg <= 16'h0000;
            cnt_reg <= 5'h0;
            tx_reg <= 8'h00;
            reading_reg <= 1'b0;
            standby_reg <= tuning_pkg::STANDBY_RESET;
            gain_reg <= 1'b0;
            tank_req_reg <= 1'b0;
            filter_req_reg <= 1'b0;
            tank_code_reg <= '0;
            filter_code_reg <= '0;
            tank_drive_reg <= '0;
            filter_drive_reg <= '0;
            run_reg <= 1'b0;
            tank_phase_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_prev_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            tx_reg <= tx_next;
            reading_reg <= reading_next;
            standby_reg <= standby_next;
            gain_reg <= gain_next;
            tank_req_reg <= tank_req_next;
            filter_req_reg <= filter_req_next;
            tank_code_reg <= tank_code_next;
            filter_code_reg <= filter_code_next;
            tank_drive_reg <= tank_drive_next;
            filter_drive_reg <= filter_drive_next;
            run_reg <= run_next;
            tank_phase_reg <= tank_phase_next;
        end
    end

    assign spi_miso_out = tx_reg[7];
    assign spi_miso_oe = !spi_cs_n && reading_reg && (cnt_reg >= HDR_CNT);
    assign gain_step_down = gain_reg;
    assign block_power_down_control = standby_reg;
    assign tank_cap_setting = tank_drive_reg;
    assign filter_cap_setting = filter_drive_reg;
    assign cal_busy = busy;
    assign converter_run = run_reg;
    assign sample_out_enable = run_reg;

    // checks
    logic [31:0] busy_cnt_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy ? busy_cnt_reg + 32'h1 : 32'h0;
        end
    end

    AST_GAIN: assert property (
        wr && waddr == tuning_pkg::ADDR_GAIN |=>
        gain_step_down == $past(wdata[tuning_pkg::GAIN_STEP_BIT]))
        else $error("gain step did not follow the write");
    AST_START_TANK: assert property (
        start && tank_req_reg |=> busy && tank_req_reg)
        else $error("tank calibration did not start");
    AST_TANK_CLEAR: assert property (
        ev.lc_done && !wr |=> !tank_req_reg)
        else $error("tank request not cleared");
    AST_LIMIT: assert property (
        busy_cnt_reg <= CAL_LIMIT_CYCLES)
        else $error("calibration ran past its bound");
    AST_TANK_CODE: assert property (
        ev.lc_done && !wr |=> tank_code_reg == $past(res_tank))
        else $error("tank code not stored");
    AST_FILTER_CLEAR: assert property (
        ev.rc_done && !wr |=> !filter_req_reg)
        else $error("filter request not cleared");
    AST_FILTER_CODE: assert property (
        ev.rc_done && !wr |=> filter_code_reg == $past(res_filter))
        else $error("filter code not stored");
    AST_ORDER: assert property (
        tank_phase_reg |-> !ev.rc_done)
        else $error("filter tuned before tank");
    AST_QUIET: assert property (
        busy |-> !converter_run && !sample_out_enable)
        else $error("converter active during calibration");
    AST_HOLD_OFF: assert property (
        $fell(busy) |-> !converter_run)
        else $error("datapath released too early");
    AST_KEEP: assert property (
        wr && waddr == tuning_pkg::ADDR_STANDBY && !busy && !ev.lc_done &&
        !ev.rc_done |=> $stable(tank_code_reg) && $stable(filter_code_reg))
        else $error("codes lost on standby change");
    AST_MANUAL: assert property (
        wr && waddr == tuning_pkg::ADDR_FILTER_CODE |=>
        filter_code_reg == $past(wdata) ##1 !busy [*1])
        else $error("manual filter code not taken");

    COV_TANK: cover property (ev.lc_done);
    COV_BOTH: cover property (ev.lc_done ##[1:1000] ev.rc_done);
    COV_TIMEOUT: cover property (ev.timeout);
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
// host controller on the serial control port: frames and tuning passes
// assumes the device samples sclk and cs_n with clk
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic miso_out,
    input wire logic miso_oe,
    output logic cs_n,
    output logic sclk,
    output logic mosi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task automatic wait_fall(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one 16-bit frame, msb first; an undriven miso reads as unknown
    task automatic xfer(input logic rd, input logic [6:0] a,
            input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        wait_fall(1);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = f[i];
            wait_fall(3);
            sclk = 1'b1;
            wait_fall(1);
            // data bit i-1 stands while sclk is high
            if (i >= 1 && i <= 8)
                q[i-1] = miso_oe ? miso_out : 1'bx;
            wait_fall(1);
            sclk = 1'b0;
        end
        mosi = ~mosi;
        wait_fall(2);
        cs_n = 1'b1;
    endtask
    // tuning pass, retried while the request flag fails to clear
    task automatic calibrate(input logic [1:0] req, output logic ok);
        logic [7:0] q;
        ok = 1'b0;
        for (int t = 0; t < 5 && !ok; t++) begin
            // clock is stable and strong inputs are absent here
            xfer(1'b0, tuning_pkg::ADDR_STANDBY, 8'h45, q);
            xfer(1'b0, tuning_pkg::ADDR_CAL_REQ, {6'h00, req}, q);
            xfer(1'b0, tuning_pkg::ADDR_STANDBY, 8'h44, q);
            for (int p = 0; p < 40 && !ok; p++) begin
                xfer(1'b1, tuning_pkg::ADDR_CAL_REQ, 8'h00, q);
                ok = (q === 8'h00);
            end
            if (!ok)
                xfer(1'b0, tuning_pkg::ADDR_CAL_REQ, 8'h00, q);
        end
    endtask
endmodule
`default_nettype wire

// *** tb/resonator_tuning_control_test.sv ***
// self-checking bench for the resonator tuning control
// assumes host_model on the serial port and a fixed comparator level
`timescale 1ns/1ps
`default_nettype none
module resonator_tuning_control_test;
    localparam int LIMIT = 2000;
    localparam int SETTLE = 2;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cmp = 1'b1;
    logic miso_out, miso_oe, cs_n, sclk, mosi, gain, busy, run, sample_en;
    logic [7:0] pdc, filter, q, filter_seen;
    logic [8:0] tank;
    logic ok;
    logic clr = 1'b0;
    int bad_count = 0;
    int checks = 0;
    int busy_cycles = 0;
    row_t rows [8] = '{'{7'h03, 8'h80, 8'h80}, '{7'h03, 8'h00, 8'h00},
        '{7'h1D, 8'hFF, 8'h07}, '{7'h1E, 8'h2A, 8'h2A},
        '{7'h1F, 8'hA5, 8'hA5}, '{7'h1C, 8'h00, 8'h00},
        '{7'h05, 8'h77, 8'h00}, '{7'h00, 8'h45, 8'h45}};
    always #5 clk = ~clk;
    host_model u_host (.clk(clk), .miso_out(miso_out), .miso_oe(miso_oe),
        .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
    resonator_tuning_control #(.CAL_LIMIT_CYCLES(LIMIT),
        .SETTLE_CYCLES(SETTLE)) u_dut (.clk(clk), .nrst(nrst),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso_out(miso_out), .spi_miso_oe(miso_oe),
        .tune_cmp_high(cmp), .gain_step_down(gain),
        .block_power_down_control(pdc), .tank_cap_setting(tank),
        .filter_cap_setting(filter), .cal_busy(busy),
        .converter_run(run), .sample_out_enable(sample_en));
    task automatic check(input string name, input logic [8:0] seen,
            input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        u_host.xfer(1'b1, a, 8'h00, q);
        check("register read", 9'(q), 9'(exp));
    endtask
    task automatic clear_count();
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask
    task automatic results();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // length of each tuning pass and the filter drive early in it
    always @(posedge clk) begin
        if (clr) begin
            busy_cycles <= 0;
        end else if (busy === 1'b1) begin
            busy_cycles <= busy_cycles + 1;
            if (busy_cycles == 6)
                filter_seen <= filter;
        end
    end
    always @(negedge clk) begin
        if (busy === 1'b1) begin
            check("converter_run", 9'(run), 9'h000);
            check("sample_out_enable", 9'(sample_en), 9'h000);
        end
    end
    initial begin
        #300_000;
        bad_count++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        check("standby", 9'(pdc), 9'h0FF);
        check("converter_run", 9'(run), 9'h000);
        check("gain_step_down", 9'(gain), 9'h000);
        rd_chk(tuning_pkg::ADDR_STANDBY, tuning_pkg::STANDBY_RESET);
        for (int i = 0; i < 8; i++) begin
            u_host.xfer(1'b0, rows[i].addr, rows[i].wdata, q);
            rd_chk(rows[i].addr, rows[i].rdata);
            if (rows[i].addr == tuning_pkg::ADDR_GAIN)
                check("gain_step_down", 9'(gain), 9'(rows[i].wdata[7]));
        end
        check("standby", 9'(pdc), 9'h045);
        check("tank drive", tank, 9'h1EA);
        check("filter drive", 9'(filter), 9'h0A5);
        // startup tuning of both resonators, comparator keeps every bit
        clear_count();
        u_host.calibrate(2'b11, ok);
        check("tuning done", 9'(ok), 9'h001);
        check("both busy", 9'(busy_cycles >= 17 * (SETTLE + 1)
            && busy_cycles < LIMIT), 9'h001);
        check("filter held", 9'(filter_seen), 9'h0A5);
        rd_chk(tuning_pkg::ADDR_TANK_UPPER, 8'h07);
        rd_chk(tuning_pkg::ADDR_TANK_LOWER, 8'h3F);
        rd_chk(tuning_pkg::ADDR_FILTER_CODE, 8'hFF);
        check("tank drive", tank, 9'h1FF);
        check("converter_run", 9'(run), 9'h001);
        check("sample_out_enable", 9'(sample_en), 9'h001);
        // filter alone, comparator drops every bit
        cmp = 1'b0;
        clear_count();
        u_host.calibrate(2'b01, ok);
        check("filter done", 9'(ok), 9'h001);
        check("filter busy", 9'(busy_cycles >= 8 * (SETTLE + 1)
            && busy_cycles < 17 * (SETTLE + 1)), 9'h001);
        rd_chk(tuning_pkg::ADDR_FILTER_CODE, 8'h00);
        rd_chk(tuning_pkg::ADDR_TANK_LOWER, 8'h3F);
        // standby round trip with no request leaves codes alone
        clear_count();
        u_host.xfer(1'b0, tuning_pkg::ADDR_STANDBY, 8'h45, q);
        u_host.xfer(1'b0, tuning_pkg::ADDR_STANDBY, 8'h44, q);
        repeat (4) @(negedge clk);
        check("no tuning", 9'(busy_cycles), 9'h000);
        check("tank kept", tank, 9'h1FF);
        rd_chk(tuning_pkg::ADDR_TANK_UPPER, 8'h07);
        // reset in mid-run restores standby and clears the stored codes
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        check("standby", 9'(pdc), 9'h0FF);
        check("converter_run", 9'(run), 9'h000);
        rd_chk(tuning_pkg::ADDR_TANK_UPPER, 8'h00);
        results();
    end
endmodule
`default_nettype wire
